/* design/ucode_device.sv */
// Purpose: drive-side interpreter for firmware download and diagnostic commands
// Assumes: host keeps to whole sectors and ascending segments
// Notes:   the image store is a word array; verification is a running checksum
`timescale 1ns/100ps
module ucode_device
    import ucode_pkg::*;
#(
    parameter int IMAGE_WORDS = 4096,
    parameter int ADDR_W      = 12
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    // link
    ucode_link_if.device    link,
    // drive conditions
    input  wire logic       i_security_locked,
    input  wire logic       i_spinup_disabled,
    input  wire logic       i_reload_fail,
    input  wire logic [7:0] i_diag_code,
    // drive actions
    output logic            o_fw_activate,
    output logic            o_spin_down,
    output logic            o_image_saved,
    output logic [31:0]     o_image_checksum
);
    import ucode_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DATA = 3'b001,
        ST_SAVE = 3'b010,
        ST_LOAD = 3'b011,
        ST_DONE = 3'b100
    } dev_state_t;

    dev_state_t  state_reg;
    logic [15:0] next_off_reg;
    logic        seg_mode_reg;
    logic        partial_reg;
    logic [22:0] words_left_reg;
    logic [ADDR_W-1:0] wr_addr_reg;
    logic [31:0] sum_reg;
    logic [7:0]  error_reg;
    logic [7:0]  status_reg;
    logic        done_reg;
    logic [15:0] load_cnt_reg;
    logic [31:0] image_mem [IMAGE_WORDS];
    logic [31:0] saved_mem [IMAGE_WORDS];
    logic [ADDR_W-1:0] save_addr_reg;
    logic        final_seg_reg;

    // --------------------------------------------------------------------
    // command decode
    // --------------------------------------------------------------------
    logic [15:0] xfer_sectors;
    logic [15:0] seg_offset;
    logic        is_dl;
    logic        bad_sub;
    logic        seq_bad;
    assign xfer_sectors = {link.lba_low, link.sector_count};
    assign seg_offset   = {link.lba_high, link.lba_mid};
    assign is_dl        = link.command == CMD_DOWNLOAD;
    assign bad_sub      = link.feature != SUB_SEGMENT && link.feature != SUB_SINGLE;
    assign seq_bad      = link.feature == SUB_SEGMENT && seg_offset != next_off_reg;

    assign link.data_ready = state_reg == ST_DATA;
    assign link.cmd_done   = done_reg;
    assign link.error_out  = error_reg;
    assign link.status_out = status_reg;

    // --------------------------------------------------------------------
    // command state machine
    // --------------------------------------------------------------------
    // a soft or hard reset wins over any command in flight
    always_ff @(posedge i_clk) begin
        done_reg      <= 1'b0;
        o_fw_activate <= 1'b0;
        o_spin_down   <= 1'b0;
        o_image_saved <= 1'b0;
        if (i_reset || link.soft_reset) begin
            state_reg      <= ST_IDLE;
            next_off_reg   <= 16'h0000;
            partial_reg    <= 1'b0;
            seg_mode_reg   <= 1'b0;
            words_left_reg <= 23'h00_0000;
            wr_addr_reg    <= '0;
            sum_reg        <= 32'h0000_0000;
            error_reg      <= 8'h00;
            status_reg     <= STATUS_RESET;
            load_cnt_reg   <= 16'h0000;
            save_addr_reg  <= '0;
            final_seg_reg  <= 1'b0;
            o_image_checksum <= 32'h0000_0000;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (link.cmd_valid) begin
                        error_reg <= 8'h00;
                        status_reg <= STATUS_RESET;
                        if (!is_dl) begin
                            // another command discards any partial image
                            next_off_reg <= 16'h0000;
                            partial_reg  <= 1'b0;
                            sum_reg      <= 32'h0000_0000;
                            wr_addr_reg  <= '0;
                            if (link.command == CMD_DIAG) begin
                                error_reg  <= i_diag_code;
                                status_reg <= 8'h00;
                            end
                            done_reg <= 1'b1;
                        end else if (bad_sub || i_security_locked || seq_bad) begin
                            error_reg[ERR_ABT_BIT]  <= 1'b1;
                            status_reg[STS_ERR_BIT] <= 1'b1;
                            next_off_reg <= 16'h0000;
                            partial_reg  <= 1'b0;
                            sum_reg      <= 32'h0000_0000;
                            wr_addr_reg  <= '0;
                            done_reg     <= 1'b1;
                        end else begin
                            seg_mode_reg   <= link.feature == SUB_SEGMENT;
                            words_left_reg <= {xfer_sectors, 7'h00};     // 128 words a sector
                            next_off_reg   <= seg_offset + xfer_sectors;
                            // the last segment is the one that fills the image
                            final_seg_reg  <= link.feature == SUB_SINGLE ||
                                ({7'h00, seg_offset + xfer_sectors, 7'h00} >= 30'(IMAGE_WORDS));
                            if (link.feature == SUB_SINGLE) begin
                                wr_addr_reg <= '0;
                                sum_reg     <= 32'h0000_0000;
                            end
                            partial_reg <= 1'b1;
                            status_reg[STS_DRQ_BIT] <= 1'b1;
                            state_reg <= (xfer_sectors == 16'h0000) ? ST_SAVE : ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (link.data_valid) begin
                        sum_reg        <= sum_reg + link.data;
                        wr_addr_reg    <= wr_addr_reg + 1'b1;
                        words_left_reg <= words_left_reg - 23'h00_0001;
                        if (words_left_reg == 23'h00_0001) begin
                            status_reg[STS_DRQ_BIT] <= 1'b0;
                            if (final_seg_reg) begin
                                save_addr_reg <= '0;
                                state_reg     <= ST_SAVE;
                            end else begin
                                done_reg  <= 1'b1;
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_SAVE: begin
                    // publish the running checksum and copy the image into the persistent store, one word a cycle
                    o_image_checksum <= sum_reg;
                    save_addr_reg <= save_addr_reg + 1'b1;
                    if (save_addr_reg == ADDR_W'(IMAGE_WORDS - 1)) begin
                        o_image_saved <= 1'b1;
                        o_fw_activate <= 1'b1;
                        load_cnt_reg  <= 16'(RELOAD_CYCLES);
                        state_reg     <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    load_cnt_reg <= load_cnt_reg - 16'h0001;
                    if (load_cnt_reg == 16'h0001) begin
                        if (i_reload_fail) begin
                            error_reg[ERR_UNC_BIT]  <= 1'b1;
                            status_reg[STS_ERR_BIT] <= 1'b1;
                        end else if (i_spinup_disabled) begin
                            o_spin_down <= 1'b1;
                        end
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    next_off_reg <= 16'h0000;
                    partial_reg  <= 1'b0;
                    sum_reg      <= 32'h0000_0000;
                    wr_addr_reg  <= '0;
                    done_reg     <= 1'b1;
                    state_reg    <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // image memories: no reset, contents are only valid while tracked
    always_ff @(posedge i_clk) begin
        if (state_reg == ST_DATA && link.data_valid) begin
            image_mem[wr_addr_reg] <= link.data;
        end
        if (state_reg == ST_SAVE) begin
            saved_mem[save_addr_reg] <= image_mem[save_addr_reg];
        end
    end
endmodule

/* design/ucode_host.sv */
// Purpose: host controller issuing download and diagnostic commands from registers
// Assumes: software writes whole-sector lengths and ascending offsets
// Notes:   avalon-mm slave with waitrequest; writes take no wait state, reads take one
`timescale 1ns/100ps
module ucode_host
    import ucode_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    // avalon-mm slave
    input  wire logic [3:0]  i_address,
    input  wire logic        i_read,
    input  wire logic        i_write,
    input  wire logic [31:0] i_writedata,
    output logic [31:0]      o_readdata,
    output logic             o_waitrequest,
    // image words from the user side
    input  wire logic        i_img_valid,
    input  wire logic [31:0] i_img_data,
    output logic             o_img_ready,
    // interrupt
    output logic             o_irq,
    // link
    ucode_link_if.host       link
);
    import ucode_pkg::*;

    logic [31:0] cmd_reg;
    logic [15:0] off_reg;
    logic [15:0] result_reg;
    logic [1:0]  irq_stat_reg;
    logic [1:0]  irq_mask_reg;
    logic        busy_reg;
    logic        go_reg;
    logic        rst_reg;
    logic        rd_ack_reg;

    // reads stall one cycle so the registered read data stands when waitrequest drops
    assign o_waitrequest = i_read && !rd_ack_reg;
    assign o_irq         = |(irq_stat_reg & irq_mask_reg);
    // --------------------------------------------------------------------
    // link drive
    // --------------------------------------------------------------------
    assign link.cmd_valid    = go_reg;
    assign link.command      = cmd_reg[31:24];
    assign link.feature      = cmd_reg[23:16];
    assign link.lba_low      = cmd_reg[15:8];
    assign link.sector_count = cmd_reg[7:0];
    assign link.lba_high     = off_reg[15:8];
    assign link.lba_mid      = off_reg[7:0];
    assign link.soft_reset   = rst_reg;
    // whole sectors are counted by the device; host just streams words
    assign link.data_valid   = busy_reg && i_img_valid;
    assign link.data         = i_img_data;
    assign o_img_ready       = busy_reg && link.data_ready;

    // register writes and command launch
    always_ff @(posedge i_clk) begin
        go_reg  <= 1'b0;
        rst_reg <= 1'b0;
        if (i_reset) begin
            cmd_reg      <= 32'h0000_0000;
            off_reg      <= 16'h0000;
            irq_mask_reg <= 2'b00;
            busy_reg     <= 1'b0;
        end else begin
            if (i_write) begin
                unique case (i_address)
                    REG_CTRL: begin
                        if (i_writedata[CTRL_GO_BIT] && !busy_reg) begin
                            go_reg   <= 1'b1;
                            busy_reg <= 1'b1;
                        end
                        if (i_writedata[CTRL_RESET_BIT]) begin
                            rst_reg  <= 1'b1;
                            busy_reg <= 1'b0;
                        end
                    end
                    REG_CMD:      cmd_reg      <= i_writedata;
                    REG_OFFSET:   off_reg      <= i_writedata[15:0];
                    REG_IRQ_MASK: irq_mask_reg <= i_writedata[1:0];
                    default: ;
                endcase
            end
            if (link.cmd_done) begin
                busy_reg <= 1'b0;
            end
        end
    end

    // result capture and sticky events; a new event beats the read clear
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            result_reg   <= 16'h0000;
            irq_stat_reg <= 2'b00;
        end else begin
            if (i_read && !rd_ack_reg && i_address == REG_IRQ_STAT) begin
                irq_stat_reg <= 2'b00;
            end
            if (link.cmd_done) begin
                result_reg <= {link.status_out, link.error_out};
                irq_stat_reg[IRQ_DONE_BIT] <= 1'b1;
                if (link.status_out[STS_ERR_BIT]) begin
                    irq_stat_reg[IRQ_ERR_BIT] <= 1'b1;
                end
            end
        end
    end

    // read wait state: high for the cycle after the first edge of a read
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rd_ack_reg <= 1'b0;
        end else begin
            rd_ack_reg <= i_read && !rd_ack_reg;
        end
    end

    // read data registered on the first edge of the read
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_readdata <= 32'h0000_0000;
        end else if (i_read && !rd_ack_reg) begin
            unique case (i_address)
                REG_CTRL:     o_readdata <= {31'h0000_0000, busy_reg};
                REG_CMD:      o_readdata <= cmd_reg;
                REG_OFFSET:   o_readdata <= {16'h0000, off_reg};
                REG_RESULT:   o_readdata <= {16'h0000, result_reg};
                REG_IRQ_STAT: o_readdata <= {30'h0000_0000, irq_stat_reg};
                REG_IRQ_MASK: o_readdata <= {30'h0000_0000, irq_mask_reg};
                REG_DEV_STAT: o_readdata <= {24'h00_0000, link.status_out};
                default:      o_readdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

/* design/ucode_link_if.sv */
// Purpose: task-file style link between host controller and drive command logic
// Assumes: single clock shared by both ends
// Notes:   data words move with valid/ready, one per accepted cycle
`timescale 1ns/100ps
interface ucode_link_if;
    logic        cmd_valid;    // host presents a command block
    logic [7:0]  command;
    logic [7:0]  feature;
    logic [7:0]  sector_count;
    logic [7:0]  lba_low;
    logic [7:0]  lba_mid;
    logic [7:0]  lba_high;
    logic        soft_reset;   // one-cycle reset pulse from host
    logic        data_valid;
    logic [31:0] data;
    logic        data_ready;
    logic        cmd_done;     // pulse: command finished
    logic [7:0]  error_out;
    logic [7:0]  status_out;
    modport host (output cmd_valid, command, feature, sector_count, lba_low, lba_mid, lba_high,
                  soft_reset, data_valid, data, input data_ready, cmd_done, error_out, status_out);
    modport device (input cmd_valid, command, feature, sector_count, lba_low, lba_mid, lba_high,
                    soft_reset, data_valid, data, output data_ready, cmd_done, error_out, status_out);
endinterface

/* design/ucode_pkg.sv */
// Purpose: shared constants for the firmware download link between host and drive
// Assumes: one clock, synchronous active-high reset
// Notes:   error and status bit positions follow the drive's command block layout
package ucode_pkg;
    // --------------------------------------------------------------------
    // command and subcommand codes
    // --------------------------------------------------------------------
    localparam logic [7:0] CMD_DOWNLOAD = 8'h92;
    localparam logic [7:0] CMD_DIAG     = 8'h90;
    localparam logic [7:0] SUB_SEGMENT  = 8'h03;
    localparam logic [7:0] SUB_SINGLE   = 8'h07;
    // --------------------------------------------------------------------
    // error register bits
    // --------------------------------------------------------------------
    localparam int ERR_UNC_BIT  = 6;
    localparam int ERR_IDN_BIT  = 4;
    localparam int ERR_ABT_BIT  = 2;
    localparam int ERR_AMN_BIT  = 0;
    // --------------------------------------------------------------------
    // status register bits
    // --------------------------------------------------------------------
    localparam int STS_BSY_BIT  = 7;
    localparam int STS_RDY_BIT  = 6;
    localparam int STS_DF_BIT   = 5;
    localparam int STS_DSC_BIT  = 4;
    localparam int STS_DRQ_BIT  = 3;
    localparam int STS_ERR_BIT  = 0;
    localparam logic [7:0] STATUS_RESET = 8'h50;  // ready and seek complete
    // --------------------------------------------------------------------
    // controller register map (avalon word addresses are byte/4)
    // --------------------------------------------------------------------
    localparam logic [3:0] REG_CTRL     = 4'h0;   // wr: bit0 go, bit1 reset pulse
    localparam logic [3:0] REG_CMD      = 4'h1;   // [31:24] cmd [23:16] feat [15:0] count
    localparam logic [3:0] REG_OFFSET   = 4'h2;   // [15:0] buffer offset
    localparam logic [3:0] REG_RESULT   = 4'h3;   // [15:8] status [7:0] error
    localparam logic [3:0] REG_IRQ_STAT = 4'h4;   // bit0 done, bit1 error; clear on read
    localparam logic [3:0] REG_IRQ_MASK = 4'h5;
    localparam logic [3:0] REG_DEV_STAT = 4'h6;   // device side status register
    localparam int CTRL_GO_BIT    = 0;
    localparam int CTRL_RESET_BIT = 1;
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_ERR_BIT    = 1;
    // --------------------------------------------------------------------
    // timing
    // --------------------------------------------------------------------
    localparam int CLK_MHZ        = 200;
    localparam int SECTOR_WORDS   = 128;      // 512 bytes in 32-bit words
    localparam int RELOAD_NS      = 100;
    localparam int RELOAD_CYCLES  = (RELOAD_NS * CLK_MHZ + 999) / 1000;
endpackage

/* tb/microcode_download_handler_tb.sv */
// Purpose: self-checking bench for host controller and drive logic joined by the link
// Assumes: image of 256 words (two sectors) to keep runs short
// Notes:   read data is taken at the edge where waitrequest is seen low
`timescale 1ns/100ps
module microcode_download_handler_tb;
    import ucode_pkg::*;
    logic        i_clk = 0, i_reset = 1, i_read = 0, i_write = 0, i_img_valid = 1;
    logic [3:0]  i_address = '0;
    logic [31:0] i_writedata = '0, i_img_data = '0, o_readdata, o_image_checksum, r, sent_sum = '0;
    logic        o_waitrequest, o_img_ready, o_irq, o_fw_activate, o_spin_down, o_image_saved;
    logic        locked = 0, spin_dis = 0, rl_fail = 0;
    logic [7:0]  diag = '0;
    logic [2:0]  seen = '0;
    int          miscompares = 0, tests_run = 0, cyc = 0;
    ucode_link_if link();
    ucode_host u_ucode_host (.i_clk(i_clk), .i_reset(i_reset), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_img_valid(i_img_valid), .i_img_data(i_img_data), .o_img_ready(o_img_ready), .o_irq(o_irq), .link(link));
    ucode_device #(.IMAGE_WORDS(256), .ADDR_W(8)) u_ucode_device (.i_clk(i_clk), .i_reset(i_reset), .link(link),
        .i_security_locked(locked), .i_spinup_disabled(spin_dis), .i_reload_fail(rl_fail), .i_diag_code(diag),
        .o_fw_activate(o_fw_activate), .o_spin_down(o_spin_down), .o_image_saved(o_image_saved),
        .o_image_checksum(o_image_checksum));
    ucode_link_checker u_ucode_link_checker (.i_clk(i_clk), .i_reset(i_reset), .cmd_valid(link.cmd_valid),
        .command(link.command), .feature(link.feature), .soft_reset(link.soft_reset),
        .data_ready(link.data_ready), .cmd_done(link.cmd_done), .error_out(link.error_out),
        .status_out(link.status_out));
    // --------------------------------------------------------------------
    // clock, image stream and pulse catchers
    // --------------------------------------------------------------------
    always #2.5 i_clk = ~i_clk;
    // a fresh word after every accepted one so a stuck pointer shows in the checksum path
    always @(posedge i_clk) begin
        if (i_img_valid && o_img_ready === 1'b1) begin // whole sectors only
            i_img_data <= i_img_data + 32'h0000_0001;
            sent_sum <= sent_sum + i_img_data;
        end
        if (o_fw_activate === 1'b1) seen[0] <= 1'b1;
        if (o_spin_down === 1'b1) seen[1] <= 1'b1;
        if (o_image_saved === 1'b1) seen[2] <= 1'b1;
    end
    // hang guard: every scenario together needs well under this
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            results();
        end
    end
    // --------------------------------------------------------------------
    // bus, compare and command tasks
    // --------------------------------------------------------------------
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge i_clk);
        i_address <= a;
        i_write <= wr;
        i_read <= !wr;
        i_writedata <= d;
        do @(posedge i_clk); while (o_waitrequest !== 1'b0);
        q = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // writes the command block, starts it, waits for the interrupt, clears it and reads the result
    task automatic run(input logic [7:0] c, input logic [7:0] f, input logic [15:0] n, input logic [15:0] o,
                       output logic [31:0] res);
        int k;
        logic [31:0] q;
        bus(1'b1, REG_CMD, {c, f, n}, q);
        bus(1'b1, REG_OFFSET, {16'h0000, o}, q);
        bus(1'b1, REG_CTRL, 32'h0000_0001, q);
        k = 0;
        while (o_irq !== 1'b1 && k < 2000) begin
            @(posedge i_clk);
            k++;
        end
        chk({31'h0, o_irq}, 32'h0000_0001);
        bus(1'b0, REG_IRQ_STAT, '0, q);
        chk({31'h0, o_irq}, 32'h0000_0000);
        bus(1'b0, REG_RESULT, '0, res);
        res = res & 32'h0000_FFFF;
    endtask
    // --------------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------------
    task automatic t_reject;
        run(CMD_DOWNLOAD, 8'h05, 16'h0002, 16'h0000, r);
        chk(r & 32'h0000_0104, 32'h0000_0104);
        locked <= 1'b1;
        run(CMD_DOWNLOAD, SUB_SINGLE, 16'h0002, 16'h0000, r);
        chk(r & 32'h0000_0104, 32'h0000_0104);
        locked <= 1'b0;
    endtask
    task automatic t_single;
        rl_fail <= 1'b1;
        run(CMD_DOWNLOAD, SUB_SINGLE, 16'h0002, 16'h0000, r);
        chk(r & 32'h0000_0040, 32'h0000_0040);
        rl_fail <= 1'b0;
        spin_dis <= 1'b1;
        seen <= '0;
        sent_sum <= '0;
        run(CMD_DOWNLOAD, SUB_SINGLE, 16'h0002, 16'h0000, r);
        chk(r, 32'h0000_5000);
        chk({29'h0, seen}, 32'h0000_0007);
        chk(o_image_checksum, sent_sum);
        spin_dis <= 1'b0;
    endtask
    task automatic t_segments;
        logic [31:0] q;
        run(CMD_DOWNLOAD, SUB_SEGMENT, 16'h0001, 16'h0000, r);
        chk(r, 32'h0000_5000);
        run(CMD_DOWNLOAD, SUB_SEGMENT, 16'h0001, 16'h0002, r);
        chk(r & 32'h0000_0104, 32'h0000_0104);
        run(CMD_DOWNLOAD, SUB_SEGMENT, 16'h0001, 16'h0000, r);
        run(CMD_DIAG, 8'h00, 16'h0000, 16'h0000, r);
        run(CMD_DOWNLOAD, SUB_SEGMENT, 16'h0001, 16'h0001, r);
        chk(r & 32'h0000_0104, 32'h0000_0104);
        run(CMD_DOWNLOAD, SUB_SEGMENT, 16'h0001, 16'h0000, r);
        bus(1'b1, REG_CTRL, 32'h0000_0002, q);
        repeat (4) @(posedge i_clk);
        bus(1'b0, REG_IRQ_STAT, '0, q);
        run(CMD_DOWNLOAD, SUB_SEGMENT, 16'h0001, 16'h0001, r);
        chk(r & 32'h0000_0104, 32'h0000_0104);
        sent_sum <= '0;
        run(CMD_DOWNLOAD, SUB_SEGMENT, 16'h0001, 16'h0000, r);
        seen <= '0;
        run(CMD_DOWNLOAD, SUB_SEGMENT, 16'h0001, 16'h0001, r);
        chk({r[15:0], 13'h0, seen}, {16'h5000, 16'h0005});
        chk(o_image_checksum, sent_sum);
    endtask
    task automatic t_diag_irq;
        logic [31:0] q;
        diag <= 8'h81;
        run(CMD_DIAG, 8'h00, 16'h0000, 16'h0000, r);
        chk(r, 32'h0000_0081);
        bus(1'b1, REG_IRQ_MASK, 32'h0000_0000, q);
        bus(1'b1, REG_CMD, {CMD_DIAG, 24'h00_0000}, q);
        bus(1'b1, REG_CTRL, 32'h0000_0001, q);
        repeat (60) @(posedge i_clk);
        chk({31'h0, o_irq}, 32'h0000_0000);
        bus(1'b0, REG_IRQ_STAT, '0, q);
        chk(q & 32'h0000_0001, 32'h0000_0001);
        bus(1'b1, REG_IRQ_MASK, 32'h0000_0003, q);
        bus(1'b0, 4'hF, '0, q);
        chk(q, 32'h0000_0000);
    endtask
    task automatic results;
        $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        logic [31:0] q;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        bus(1'b1, REG_IRQ_MASK, 32'h0000_0003, q);
        t_reject();
        t_single();
        t_segments();
        t_diag_irq();
        results();
    end
endmodule

/* tb/ucode_link_checker.sv */
// Purpose: concurrent checks on the host to drive command link
// Assumes: one clock, synchronous active-high reset
// Notes:   watches only interface signals; drive conditions are judged by the bench
`timescale 1ns/100ps
module ucode_link_checker
    import ucode_pkg::*;
(
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_reset,
    // link signals
    input wire logic       cmd_valid,
    input wire logic [7:0] command,
    input wire logic [7:0] feature,
    input wire logic       soft_reset,
    input wire logic       data_ready,
    input wire logic       cmd_done,
    input wire logic [7:0] error_out,
    input wire logic [7:0] status_out
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    // ----------------------------------------------------------------
    // command sequences
    // ----------------------------------------------------------------
    sequence s_bad_sub;
        cmd_valid && command == CMD_DOWNLOAD && feature != SUB_SEGMENT && feature != SUB_SINGLE;
    endsequence
    sequence s_abort_done;
        ##[1:40] cmd_done && error_out[ERR_ABT_BIT];
    endsequence
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    property p_bad_sub_abort;
        s_bad_sub |-> s_abort_done;
    endproperty
    property p_bad_sub_no_data;
        s_bad_sub |=> !data_ready [*3];
    endproperty
    property p_diag_status;
        cmd_valid && command == CMD_DIAG |-> ##[1:40] cmd_done && status_out == 8'h00;
    endproperty
    // a whole image plus save and reload fits well inside this bound
    property p_single_done;
        cmd_valid && command == CMD_DOWNLOAD && feature == SUB_SINGLE |-> ##[1:1000] cmd_done;
    endproperty
    property p_ready_after_cmd;
        $rose(data_ready) |-> $past(cmd_valid);
    endproperty
    property p_soft_reset_drop;
        soft_reset |=> !data_ready;
    endproperty
    property p_done_pulse;
        cmd_done |=> !cmd_done;
    endproperty
    property p_reset_status;
        $fell(i_reset) |-> status_out == STATUS_RESET;
    endproperty
    a_bad_sub_abort: assert property (p_bad_sub_abort) else $error("reserved subcommand not aborted");
    a_bad_sub_no_data: assert property (p_bad_sub_no_data) else $error("data taken on bad subcommand");
    a_diag_status: assert property (p_diag_status) else $error("diagnostic status wrong");
    a_single_done: assert property (p_single_done) else $error("single download never finished");
    a_ready_after_cmd: assert property (p_ready_after_cmd) else $error("data ready without command");
    a_soft_reset_drop: assert property (p_soft_reset_drop) else $error("transfer kept after reset");
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
    a_reset_status: assert property (p_reset_status) else $error("status after reset wrong");
endmodule
